//--- logic/pps_regs.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps

//Contract
// - Power register bit 7 selects separate or shared power and sense pins.
// - Power register bit 5 set marks the port permanently disabled to hub logic.
// - Power register bit 4 set flags a permanently attached device.
// - Source code 0 keeps power off, 1 follows USB2, 2 follows USB3.
// - Source code 3 powers on either state, code 4 follows gpio.
// - Sense code 0 disables, 1 takes sense pin, 2 takes gpio.
// - Sense code 15 forces sense on, for test only.
// - Unlisted source and sense codes are reserved, no defined behaviour.
module pps_regs
(
	input  wire logic                       clk_sys_i,       // System clock, 200 MHz
	input  wire logic                       resetn_i,        // Async reset, active low
	input  wire logic [pps_pkg::ADDR_W-1:0] addr_i,          // Register byte address
	input  wire logic [pps_pkg::DATA_W-1:0] wdata_i,         // Write data
	input  wire logic                       wr_i,            // Write strobe
	input  wire logic                       rd_i,            // Read strobe
	output logic      [pps_pkg::DATA_W-1:0] rdata_o,         // Read data, next cycle
	input  wire logic [1:0]                 usb2_pwr_i,      // USB2 power state, ports 6/7
	input  wire logic [1:0]                 usb3_pwr_i,      // USB3 power state, ports 6/7
	input  wire logic [1:0]                 pwr_gpio_i,      // Power gpio pins, ports 6/7
	input  wire logic [1:0]                 ocs_pin_i,       // Sense pins, ports 1/2
	input  wire logic [1:0]                 ocs_gpio_i,      // Sense gpio pins, ports 1/2
	output logic      [1:0]                 port_pwr_o,      // Power enable, ports 6/7
	output logic      [1:0]                 port_disabled_o, // Unavailable, ports 6/7
	output logic      [1:0]                 fixed_attached_device_o, // Ports 6/7
	output logic      [1:0]                 combined_mode_o, // Shared pins, ports 6/7
	output logic      [1:0]                 overcurrent_sense_o, // Sense, ports 1/2
	output logic      [1:0]                 ocs_disabled_o   // Sense off, ports 1/2
);
	import pps_pkg::*;

	logic [DATA_W-1:0] pwr_cfg_q [2];
	logic [DATA_W-1:0] ocs_cfg_q [2];
	logic [PIN_N-1:0]  pin_meta_q;
	logic [PIN_N-1:0]  pin_sync_q;
	logic [1:0]        pwr_gpio_s;
	logic [1:0]        ocs_pin_s;
	logic [1:0]        ocs_gpio_s;
	logic [1:0]        pwr_rsvd;
	logic [1:0]        ocs_rsvd_q;
	logic [DATA_W-1:0] status;
	logic [DATA_W-1:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser for all pin inputs
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end
		else
		begin
			pin_meta_q <= {ocs_gpio_i, ocs_pin_i, pwr_gpio_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign pwr_gpio_s = pin_sync_q[1:0];
	assign ocs_pin_s  = pin_sync_q[3:2];
	assign ocs_gpio_s = pin_sync_q[5:4];

	////////////////////////////////////////////////////////////////////////////////
	// Power registers, bit 6 never stored
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pwr_cfg_q[0] <= PWR_CFG_RST;
			pwr_cfg_q[1] <= PWR_CFG_RST;
		end
		else if (wr_i)
		begin
			if (addr_i == PORT6_POWER_OFS)
				pwr_cfg_q[0] <= wdata_i & PWR_WR_MASK;
			if (addr_i == PORT7_POWER_OFS)
				pwr_cfg_q[1] <= wdata_i & PWR_WR_MASK;
		end
	end

	// Over-current registers, all eight bits stored
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ocs_cfg_q[0] <= OCS_CFG_RST;
			ocs_cfg_q[1] <= OCS_CFG_RST;
		end
		else if (wr_i)
		begin
			if (addr_i == PORT1_OCS_OFS)
				ocs_cfg_q[0] <= wdata_i;
			if (addr_i == PORT2_OCS_OFS)
				ocs_cfg_q[1] <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power decode for ports 6 and 7
	generate
		for (genvar p = 0; p < 2; p++)
		begin : g_pwr
			pps_pwr_dec u_dec
			(
				.clk_sys_i  (clk_sys_i),
				.resetn_i   (resetn_i),
				.cfg_i      (pwr_cfg_q[p]),
				.usb2_pwr_i (usb2_pwr_i[p]),
				.usb3_pwr_i (usb3_pwr_i[p]),
				.gpio_pwr_i (pwr_gpio_s[p]),
				.pwr_o      (port_pwr_o[p]),
				.disabled_o (port_disabled_o[p]),
				.fixed_o    (fixed_attached_device_o[p]),
				.combined_o (combined_mode_o[p]),
				.rsvd_o     (pwr_rsvd[p])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Over-current source selection for ports 1 and 2; upper bits unused
	generate
		for (genvar o = 0; o < 2; o++)
		begin : g_ocs
			always_ff @(posedge clk_sys_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					overcurrent_sense_o[o] <= 1'b0;
					ocs_disabled_o[o]      <= 1'b0;
					ocs_rsvd_q[o]          <= 1'b0;
				end
				else
				begin
					ocs_disabled_o[o] <= 1'b0;
					ocs_rsvd_q[o]     <= 1'b0;
					case (ocs_cfg_q[o][SRC_MSB:SRC_LSB])
						OCS_SRC_OFF:
						begin
							overcurrent_sense_o[o] <= 1'b0;
							ocs_disabled_o[o]      <= 1'b1;
						end
						OCS_SRC_PIN:   overcurrent_sense_o[o] <= ocs_pin_s[o];
						OCS_SRC_GPIO:  overcurrent_sense_o[o] <= ocs_gpio_s[o];
						OCS_SRC_FORCE: overcurrent_sense_o[o] <= 1'b1;
						default:
						begin
							overcurrent_sense_o[o] <= 1'b0;
							ocs_rsvd_q[o]          <= 1'b1;
						end
					endcase
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Status view of live port state
	assign status = {ocs_rsvd_q, pwr_rsvd, overcurrent_sense_o, port_pwr_o};

	// Read selection, unmapped addresses read zero
	always_comb
	begin
		rd_mux = '0;
		case (addr_i)
			PORT6_POWER_OFS: rd_mux = pwr_cfg_q[0];
			PORT7_POWER_OFS: rd_mux = pwr_cfg_q[1];
			PORT1_OCS_OFS:   rd_mux = ocs_cfg_q[0];
			PORT2_OCS_OFS:   rd_mux = ocs_cfg_q[1];
			PORT_STATUS_OFS: rd_mux = status;
			default:         rd_mux = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_o <= '0;
		else if (rd_i)
			rdata_o <= rd_mux;
		else
			rdata_o <= '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_ocs_pin_path: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_cfg_q[0][3:0] == OCS_SRC_PIN) [*4] |-> overcurrent_sense_o[0] == $past(ocs_pin_i[0], 3))
		else $error("port1 sense not from pin");
	a_ocs_gpio_path: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_cfg_q[1][3:0] == OCS_SRC_GPIO) [*4] |-> overcurrent_sense_o[1] == $past(ocs_gpio_i[1], 3))
		else $error("port2 sense not from gpio");
	a_ocs_force_on: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_cfg_q[0][3:0] == OCS_SRC_FORCE) |=> overcurrent_sense_o[0])
		else $error("forced sense not on");
	a_ocs_off_ignored: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_cfg_q[1][3:0] == OCS_SRC_OFF) |=> !overcurrent_sense_o[1] && ocs_disabled_o[1])
		else $error("disabled port reports sense");
	a_ocs_rsvd_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		ocs_rsvd_q[0] |-> !overcurrent_sense_o[0]) else $error("reserved sense code active");
	a_rsvd_bit_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(rd_i && addr_i == PORT6_POWER_OFS) |=> !rdata_o[PWR_RSVD_BIT])
		else $error("power reserved bit reads one");
	a_write_readback: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_i && addr_i == PORT1_OCS_OFS) ##1 (rd_i && !wr_i && addr_i == PORT1_OCS_OFS)
		|=> rdata_o == $past(wdata_i, 2)) else $error("sense register readback wrong");
	a_read_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!rd_i |=> rdata_o == '0) else $error("read data outside its cycle");
	a_status_power: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(rd_i && addr_i == PORT_STATUS_OFS) |=> rdata_o[1:0] == $past(port_pwr_o))
		else $error("status power bits wrong");

	// Synchroniser and register storage
	a_sync_shift: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		pin_sync_q == $past(pin_meta_q)) else $error("pin synchroniser not shifting");
	a_sync_capture: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		$past(resetn_i) |-> pin_meta_q == $past({ocs_gpio_i, ocs_pin_i, pwr_gpio_i}))
		else $error("pin synchroniser missed input");
	a_pwr6_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_i && addr_i == PORT6_POWER_OFS) |=> pwr_cfg_q[0] == ($past(wdata_i) & PWR_WR_MASK))
		else $error("port6 power write wrong");
	a_pwr7_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_i && addr_i == PORT7_POWER_OFS) |=> pwr_cfg_q[1] == ($past(wdata_i) & PWR_WR_MASK))
		else $error("port7 power write wrong");
	a_ocs1_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_i && addr_i == PORT1_OCS_OFS) |=> ocs_cfg_q[0] == $past(wdata_i))
		else $error("port1 sense write wrong");
	a_ocs2_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_i && addr_i == PORT2_OCS_OFS) |=> ocs_cfg_q[1] == $past(wdata_i))
		else $error("port2 sense write wrong");
	a_rsvd_not_stored: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!pwr_cfg_q[0][PWR_RSVD_BIT] && !pwr_cfg_q[1][PWR_RSVD_BIT])
		else $error("power reserved bit stored");
	a_cfg_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!wr_i |=> $stable(pwr_cfg_q[0]) && $stable(pwr_cfg_q[1])
		&& $stable(ocs_cfg_q[0]) && $stable(ocs_cfg_q[1]))
		else $error("config changed without a write");

	// Further sense paths of both ports
	a_ocs_pin_port2: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_cfg_q[1][3:0] == OCS_SRC_PIN) [*4] |-> overcurrent_sense_o[1] == $past(ocs_pin_i[1], 3))
		else $error("port2 sense not from pin");
	a_ocs_gpio_port1: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_cfg_q[0][3:0] == OCS_SRC_GPIO) [*4] |-> overcurrent_sense_o[0] == $past(ocs_gpio_i[0], 3))
		else $error("port1 sense not from gpio");
	a_ocs_force_port2: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_cfg_q[1][3:0] == OCS_SRC_FORCE) |=> overcurrent_sense_o[1])
		else $error("port2 forced sense not on");
	a_ocs_off_port1: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_cfg_q[0][3:0] == OCS_SRC_OFF) |=> !overcurrent_sense_o[0] && ocs_disabled_o[0])
		else $error("port1 disabled reports sense");
	a_ocs_dis_code: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		ocs_disabled_o[0] |-> $past(ocs_cfg_q[0][3:0]) == OCS_SRC_OFF)
		else $error("sense off without off code");
	a_ocs_dis_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_disabled_o & overcurrent_sense_o) == 2'b00) else $error("sense on while off");
	a_rsvd_sense_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ocs_rsvd_q & overcurrent_sense_o) == 2'b00) else $error("reserved sense active");

	// Read data and port flags
	a_rsvd_bit7_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(rd_i && addr_i == PORT7_POWER_OFS) |=> !rdata_o[PWR_RSVD_BIT])
		else $error("port7 reserved bit reads one");
	a_rd_unmapped: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(rd_i && addr_i != PORT6_POWER_OFS && addr_i != PORT7_POWER_OFS
		&& addr_i != PORT1_OCS_OFS && addr_i != PORT2_OCS_OFS && addr_i != PORT_STATUS_OFS)
		|=> rdata_o == '0) else $error("unmapped read not zero");
	a_status_sense: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(rd_i && addr_i == PORT_STATUS_OFS) |=> rdata_o[3:2] == $past(overcurrent_sense_o))
		else $error("status sense bits wrong");
	a_status_rsvd: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(rd_i && addr_i == PORT_STATUS_OFS) |=> rdata_o[7:4] == $past({ocs_rsvd_q, pwr_rsvd}))
		else $error("status reserved bits wrong");
	a_disabled_track: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		port_disabled_o == $past({pwr_cfg_q[1][PWR_DISABLE_BIT],
		pwr_cfg_q[0][PWR_DISABLE_BIT]})) else $error("disabled flags lag config");
	a_combined_track: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		combined_mode_o == $past({pwr_cfg_q[1][PWR_COMBINED_BIT],
		pwr_cfg_q[0][PWR_COMBINED_BIT]})) else $error("combined flags lag config");
	a_fixed_track: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		fixed_attached_device_o == $past({pwr_cfg_q[1][PWR_FIXED_BIT],
		pwr_cfg_q[0][PWR_FIXED_BIT]})) else $error("fixed flags lag config");
	a_pwr_disabled_port: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(port_disabled_o & port_pwr_o) == 2'b00) else $error("disabled port has power");
	a_rsvd_pwr_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(pwr_rsvd & port_pwr_o) == 2'b00) else $error("reserved power code active");

	c_pwr_gpio_on: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		pwr_cfg_q[0][3:0] == PWR_SRC_GPIO ##1 port_pwr_o[0]);
	c_ocs_force: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		ocs_cfg_q[1][3:0] == OCS_SRC_FORCE ##1 overcurrent_sense_o[1]);
	c_port_disabled: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		port_disabled_o[1] && fixed_attached_device_o[1]);
	c_status_read: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rd_i && addr_i == PORT_STATUS_OFS);

endmodule : pps_regs

//--- logic/pps_pkg.sv
package pps_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus shape
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// Register byte offsets
	localparam logic [15:0] PORT6_POWER_OFS = 16'h3c14;
	localparam logic [15:0] PORT7_POWER_OFS = 16'h3c18;
	localparam logic [15:0] PORT1_OCS_OFS   = 16'h3c20;
	localparam logic [15:0] PORT2_OCS_OFS   = 16'h3c24;
	localparam logic [15:0] PORT_STATUS_OFS = 16'h3c40;

	////////////////////////////////////////////////////////////////////////////////
	// Power register field positions
	localparam int PWR_COMBINED_BIT = 7;
	localparam int PWR_RSVD_BIT     = 6;
	localparam int PWR_DISABLE_BIT  = 5;
	localparam int PWR_FIXED_BIT    = 4;
	localparam int SRC_MSB          = 3;
	localparam int SRC_LSB          = 0;

	// Writable bits of a power register (bit 6 stays zero)
	localparam logic [7:0] PWR_WR_MASK = 8'hbf;

	// Power source codes
	localparam logic [3:0] PWR_SRC_OFF    = 4'h0;
	localparam logic [3:0] PWR_SRC_USB2   = 4'h1;
	localparam logic [3:0] PWR_SRC_USB3   = 4'h2;
	localparam logic [3:0] PWR_SRC_EITHER = 4'h3;
	localparam logic [3:0] PWR_SRC_GPIO   = 4'h4;

	// Over-current source codes
	localparam logic [3:0] OCS_SRC_OFF   = 4'h0;
	localparam logic [3:0] OCS_SRC_PIN   = 4'h1;
	localparam logic [3:0] OCS_SRC_GPIO  = 4'h2;
	localparam logic [3:0] OCS_SRC_FORCE = 4'hf;

	////////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [7:0] PWR_CFG_RST = 8'h00;
	localparam logic [7:0] OCS_CFG_RST = 8'h00;

	// Pin synchroniser width: two power gpio, two ocs pins, two ocs gpio
	localparam int PIN_N = 6;

endpackage : pps_pkg

//--- logic/pps_pwr_dec.sv
`timescale 1ns/1ps

// Decodes one port power register into registered port controls
module pps_pwr_dec
(
	input  wire logic                      clk_sys_i,  // System clock
	input  wire logic                      resetn_i,   // Async reset, active low
	input  wire logic [pps_pkg::DATA_W-1:0] cfg_i,     // Power register value
	input  wire logic                      usb2_pwr_i, // USB2 port power state
	input  wire logic                      usb3_pwr_i, // USB3 port power state
	input  wire logic                      gpio_pwr_i, // Synchronised gpio level
	output logic                           pwr_o,      // Port power enable
	output logic                           disabled_o, // Port unavailable
	output logic                           fixed_o,    // Non-removable device
	output logic                           combined_o, // Shared power/sense pins
	output logic                           rsvd_o      // Reserved source code
);
	import pps_pkg::*;

	logic [3:0] src;
	logic       dis;

	assign src = cfg_i[SRC_MSB:SRC_LSB];
	assign dis = cfg_i[PWR_DISABLE_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Power source selection, disabled port held off
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pwr_o  <= 1'b0;
			rsvd_o <= 1'b0;
		end
		else
		begin
			rsvd_o <= 1'b0;
			if (dis)
				pwr_o <= 1'b0;
			else
			begin
				case (src)
					PWR_SRC_OFF:    pwr_o <= 1'b0;
					PWR_SRC_USB2:   pwr_o <= usb2_pwr_i;
					PWR_SRC_USB3:   pwr_o <= usb3_pwr_i;
					PWR_SRC_EITHER: pwr_o <= usb2_pwr_i | usb3_pwr_i;
					PWR_SRC_GPIO:   pwr_o <= gpio_pwr_i;
					default:
					begin
						pwr_o  <= 1'b0;
						rsvd_o <= 1'b1;
					end
				endcase
			end
		end
	end

	// Port attribute flags toward the hub logic
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			disabled_o <= 1'b0;
			fixed_o    <= 1'b0;
			combined_o <= 1'b0;
		end
		else
		begin
			disabled_o <= dis;
			fixed_o    <= cfg_i[PWR_FIXED_BIT];
			combined_o <= cfg_i[PWR_COMBINED_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_pwr_src_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(src == PWR_SRC_OFF) |=> !pwr_o) else $error("power on with off code");
	a_pwr_follow_usb2: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(!dis && src == PWR_SRC_USB2) |=> pwr_o == $past(usb2_pwr_i))
		else $error("power not following usb2");
	a_pwr_follow_usb3: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(!dis && src == PWR_SRC_USB3) |=> pwr_o == $past(usb3_pwr_i))
		else $error("power not following usb3");
	a_pwr_either_on: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(!dis && src == PWR_SRC_EITHER) |=> pwr_o == ($past(usb2_pwr_i) | $past(usb3_pwr_i)))
		else $error("power not either state");
	a_pwr_follow_gpio: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(!dis && src == PWR_SRC_GPIO) |=> pwr_o == $past(gpio_pwr_i))
		else $error("power not following gpio");
	a_pwr_disable_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		dis [*2] |-> !pwr_o && disabled_o) else $error("disabled port powered");
	a_pwr_rsvd_off: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		rsvd_o |-> !pwr_o && src > PWR_SRC_GPIO || $changed(cfg_i))
		else $error("reserved code powered port");
	a_pwr_flags_track: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		##1 (fixed_o == $past(cfg_i[PWR_FIXED_BIT]) && combined_o == $past(cfg_i[PWR_COMBINED_BIT])))
		else $error("port flags lag config");

endmodule : pps_pwr_dec

//--- tb/pps_regs_bench.sv
`timescale 1ns/1ps

module pps_regs_bench;
	import pps_pkg::*;

	logic              clk_sys_i;               // System clock
	logic              resetn_i;                // Reset, active low
	logic [ADDR_W-1:0] addr_i;                  // Register address
	logic [DATA_W-1:0] wdata_i;                 // Write data
	logic              wr_i;                    // Write strobe
	logic              rd_i;                    // Read strobe
	logic [DATA_W-1:0] rdata_o;                 // Read data
	logic [1:0]        usb2_pwr_i;              // USB2 power states
	logic [1:0]        usb3_pwr_i;              // USB3 power states
	logic [1:0]        pwr_gpio_i;              // Power gpio pins
	logic [1:0]        ocs_pin_i;               // Sense pins
	logic [1:0]        ocs_gpio_i;              // Sense gpio pins
	logic [1:0]        port_pwr_o;              // Power enables
	logic [1:0]        port_disabled_o;         // Port unavailable
	logic [1:0]        fixed_attached_device_o; // Non-removable device
	logic [1:0]        combined_mode_o;         // Shared pins
	logic [1:0]        overcurrent_sense_o;     // Sense outputs
	logic [1:0]        ocs_disabled_o;          // Sense off
	int                miscompares;             // Mismatch count
	int                checks_done;             // Comparison count

	////////////////////////////////////////////////////////////////////////////////
	// Device under test
	pps_regs dut_u
	(
		.clk_sys_i               (clk_sys_i),
		.resetn_i                (resetn_i),
		.addr_i                  (addr_i),
		.wdata_i                 (wdata_i),
		.wr_i                    (wr_i),
		.rd_i                    (rd_i),
		.rdata_o                 (rdata_o),
		.usb2_pwr_i              (usb2_pwr_i),
		.usb3_pwr_i              (usb3_pwr_i),
		.pwr_gpio_i              (pwr_gpio_i),
		.ocs_pin_i               (ocs_pin_i),
		.ocs_gpio_i              (ocs_gpio_i),
		.port_pwr_o              (port_pwr_o),
		.port_disabled_o         (port_disabled_o),
		.fixed_attached_device_o (fixed_attached_device_o),
		.combined_mode_o         (combined_mode_o),
		.overcurrent_sense_o     (overcurrent_sense_o),
		.ocs_disabled_o          (ocs_disabled_o)
	);

	// Clock of 5 ns period
	initial
	begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus and check helpers
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask : wr_reg

	// Read data is taken in the single cycle after the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd_reg

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Covers the three-edge gpio synchroniser with margin
	task automatic settle;
		repeat (4) @(posedge clk_sys_i);
		#1;
	endtask : settle

	task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(what, exp, d);
	endtask : rd_chk

	// Expected power enable for a source code
	function automatic logic pwr_exp(input logic [3:0] c, input logic u2, u3, g);
		case (c)
			PWR_SRC_USB2:   return u2;
			PWR_SRC_USB3:   return u3;
			PWR_SRC_EITHER: return u2 | u3;
			PWR_SRC_GPIO:   return g;
			default:        return 1'b0;
		endcase
	endfunction : pwr_exp

	// Expected sense for a sense code
	function automatic logic ocs_exp(input logic [3:0] c, input logic p, g);
		case (c)
			OCS_SRC_PIN:   return p;
			OCS_SRC_GPIO:  return g;
			OCS_SRC_FORCE: return 1'b1;
			default:       return 1'b0;
		endcase
	endfunction : ocs_exp

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_reset;
		rd_chk("port6 power reg", PORT6_POWER_OFS, PWR_CFG_RST);
		rd_chk("port7 power reg", PORT7_POWER_OFS, PWR_CFG_RST);
		rd_chk("port1 sense reg", PORT1_OCS_OFS, OCS_CFG_RST);
		rd_chk("port2 sense reg", PORT2_OCS_OFS, OCS_CFG_RST);
		chk("port flags", 8'h00, {port_pwr_o, port_disabled_o, fixed_attached_device_o,
			combined_mode_o});
		chk("sense off", 8'h03, {4'h0, overcurrent_sense_o, ocs_disabled_o});
		$display("test reset done");
	endtask : test_reset

	// Every power code, reserved one too, against all input mixes
	task automatic test_power;
		logic [1:0] e;
		for (int c = 0; c < 6; c++)
		begin
			wr_reg(PORT6_POWER_OFS, {4'h0, c[3:0]});
			wr_reg(PORT7_POWER_OFS, {4'h0, c[3:0]});
			for (int v = 0; v < 8; v++)
			begin
				@(posedge clk_sys_i);
				usb2_pwr_i <= {~v[0], v[0]};
				usb3_pwr_i <= {~v[1], v[1]};
				pwr_gpio_i <= {~v[2], v[2]};
				settle();
				e = {pwr_exp(c[3:0], ~v[0], ~v[1], ~v[2]), pwr_exp(c[3:0], v[0], v[1], v[2])};
				chk("port power", {6'h0, e}, {6'h0, port_pwr_o});
			end
		end
		$display("test power done");
	endtask : test_power

	// Flag bits, read-only bit 6 and disable overriding a live source
	task automatic test_bits;
		wr_reg(PORT6_POWER_OFS, 8'hb1);
		wr_reg(PORT7_POWER_OFS, 8'h51);
		@(posedge clk_sys_i);
		usb2_pwr_i <= 2'b11;
		settle();
		chk("port power", 8'h02, {6'h0, port_pwr_o});
		chk("port disabled", 8'h01, {6'h0, port_disabled_o});
		chk("fixed device", 8'h03, {6'h0, fixed_attached_device_o});
		chk("combined mode", 8'h01, {6'h0, combined_mode_o});
		rd_chk("port6 power reg", PORT6_POWER_OFS, 8'hb1);
		rd_chk("port7 power reg", PORT7_POWER_OFS, 8'h11);
		$display("test bits done");
	endtask : test_bits

	// Every sense code, reserved one too, with upper bits stored
	task automatic test_ocs;
		logic [3:0] codes [5];
		logic [1:0] e;
		codes = '{OCS_SRC_OFF, OCS_SRC_PIN, OCS_SRC_GPIO, 4'h3, OCS_SRC_FORCE};
		for (int i = 0; i < 5; i++)
		begin
			wr_reg(PORT1_OCS_OFS, {4'ha, codes[i]});
			wr_reg(PORT2_OCS_OFS, {4'h5, codes[i]});
			rd_chk("port1 sense reg", PORT1_OCS_OFS, {4'ha, codes[i]});
			for (int v = 0; v < 4; v++)
			begin
				@(posedge clk_sys_i);
				ocs_pin_i  <= {~v[0], v[0]};
				ocs_gpio_i <= {~v[1], v[1]};
				settle();
				e = {ocs_exp(codes[i], ~v[0], ~v[1]), ocs_exp(codes[i], v[0], v[1])};
				chk("sense", {6'h0, e}, {6'h0, overcurrent_sense_o});
				chk("sense off", {6'h0, {2{codes[i] == 4'h0}}}, {6'h0, ocs_disabled_o});
			end
		end
		$display("test ocs done");
	endtask : test_ocs

	// Write then read of port2 with an idle cycle between, and an unmapped address
	task automatic test_bus;
		wr_reg(PORT2_OCS_OFS, 8'h7e);
		rd_chk("port2 sense reg", PORT2_OCS_OFS, 8'h7e);
		wr_reg(16'h3c1c, 8'hff);
		rd_chk("unmapped", 16'h3c1c, 8'h00);
		rd_chk("port1 sense reg", PORT1_OCS_OFS, 8'haf);
		$display("test bus done");
	endtask : test_bus

	// Status view, then a write and a read of one register with no gap
	task automatic test_status;
		wr_reg(PORT6_POWER_OFS, 8'h05);
		wr_reg(PORT7_POWER_OFS, 8'h01);
		wr_reg(PORT1_OCS_OFS, {4'h0, OCS_SRC_FORCE});
		wr_reg(PORT2_OCS_OFS, 8'h03);
		@(posedge clk_sys_i);
		usb2_pwr_i <= 2'b10;
		settle();
		rd_chk("status", PORT_STATUS_OFS, 8'h96);
		@(posedge clk_sys_i);
		addr_i  <= PORT1_OCS_OFS;
		wdata_i <= 8'h31;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		chk("port1 sense reg", 8'h31, rdata_o);
		@(posedge clk_sys_i);
		#1;
		chk("read data after", 8'h00, rdata_o);
		$display("test status done");
	endtask : test_status

	////////////////////////////////////////////////////////////////////////////////
	// Verdict
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	// Watchdog, well beyond the expected run
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		miscompares++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		miscompares = 0;
		checks_done = 0;
		resetn_i    = 1'b0;
		addr_i      = '0;
		wdata_i     = '0;
		wr_i        = 1'b0;
		rd_i        = 1'b0;
		usb2_pwr_i  = 2'b00;
		usb3_pwr_i  = 2'b00;
		pwr_gpio_i  = 2'b00;
		ocs_pin_i   = 2'b00;
		ocs_gpio_i  = 2'b00;
		repeat (5) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		settle();
		test_reset();
		test_power();
		test_bits();
		test_ocs();
		test_bus();
		test_status();
		stop_test();
	end

endmodule : pps_regs_bench
